// ---- boot_uart_autodetect.sv ----
`timescale 1ns/1ps
// boot entry, port autodetect and baud measurement
module boot_uart_autodetect
    import boot_uart_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // boot straps
    input wire logic BOOT_SELECT_PIN_IN,
    input wire logic BOOT_SELECT_OPTION_BIT_IN,
    // serial port a
    input wire logic PORT_A_RECEIVE_IN,
    output logic PORT_A_TRANSMIT_OUT,
    // serial port b
    input wire logic PORT_B_RECEIVE_IN,
    output logic PORT_B_TRANSMIT_OUT,
    // register port
    input wire logic [7:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    // system status
    output logic LOADER_MODE_OUT,
    output logic DEBUG_LINK_BLOCKED_OUT,
    output logic WDG_REFRESH_OUT,
    output logic [3:0] WDG_PRESCALE_OUT,
    output logic [1:0] FLASH_WAIT_OUT
);
    // ******************************
    // reset release and pin synchronisers
    // ******************************
    logic [1:0] rst_sync_reg; // reset release chain
    logic rst_n; // released reset
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) rst_sync_reg <= 2'b00;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];
    logic [3:0] pin_s1_reg; // first stage, read only by second
    logic [3:0] pin_s2_reg; // safe copies
    // raw reset, so the straps have settled before the machine wakes
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pin_s1_reg <= 4'hf;
            pin_s2_reg <= 4'hf;
        end else begin
            pin_s1_reg <= {BOOT_SELECT_OPTION_BIT_IN, BOOT_SELECT_PIN_IN,
                           PORT_B_RECEIVE_IN, PORT_A_RECEIVE_IN};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    // ******************************
    // port engines (only rx and tx used)
    // ******************************
    serial_port_if port_a ();
    serial_port_if port_b ();
    serial_engine u_eng_a (.clk_in(CLK_IN), .rst_n_in(rst_n), .sp(port_a));
    serial_engine u_eng_b (.clk_in(CLK_IN), .rst_n_in(rst_n), .sp(port_b));
    // ******************************
    // state
    // ******************************
    typedef struct packed {
        sel_state_t st;
        logic strap_done; // straps taken after release
        logic loader; // loader mode latched
        logic sel_b; // chosen port is b
        logic [1:0] en; // per-port enable
        logic prev_line; // last level of measured line
        logic [2:0] low_seen; // low runs measured
        logic [DIV_W-1:0] tick; // tick timer
        logic [DIV_W-1:0] low_sum; // accumulated low time
        logic [DIV_W-1:0] divisor; // cycles per bit
        logic [7:0] rx_byte; // last command byte
        logic rx_new; // unread byte flag
        logic perr; // sticky frame fault
        logic [7:0] tx_byte;
        logic tx_go;
        logic [31:0] rdata;
        logic [31:0] wdg_cnt;
        logic wdg_pulse;
    } top_t;
    top_t t_reg, t_next;
    // current line of a port
    function automatic logic line_of(input logic b, input logic [3:0] pins);
        line_of = b ? pins[1] : pins[0];
    endfunction : line_of
    // commands this loader accepts without a NACK
    function automatic logic cmd_known(input logic [7:0] c);
        cmd_known = (c == CMD_GET) || (c == CMD_VERSION) || (c == CMD_ID);
    endfunction : cmd_known
    logic cur_line;
    assign cur_line = line_of(t_reg.sel_b, pin_s2_reg);
    logic rx_fault; // frame fault on a byte landing this cycle
    assign rx_fault = (t_reg.st == ST_CMD) && (t_reg.sel_b ? port_b.rx_valid && port_b.rx_perr
        : port_a.rx_valid && port_a.rx_perr);
    // ******************************
    // next state
    // ******************************
    always_comb begin
        t_next = t_reg;
        t_next.tx_go = 1'b0;
        t_next.wdg_pulse = 1'b0;
        // strap capture one cycle after release
        if (!t_reg.strap_done) begin
            t_next.strap_done = 1'b1;
            t_next.loader = pin_s2_reg[2] & pin_s2_reg[3];
        end
        // periodic watchdog refresh while loader runs
        if (t_reg.loader) begin
            if (t_reg.wdg_cnt == 32'(WDG_REFRESH_CYC - 1)) begin
                t_next.wdg_cnt = '0;
                t_next.wdg_pulse = 1'b1;
            end else begin
                t_next.wdg_cnt = t_reg.wdg_cnt + 32'h1;
            end
        end
        t_next.prev_line = cur_line;
        unique case (t_reg.st)
            ST_IDLE: begin
                t_next.en = 2'b00;
                if (t_reg.strap_done && t_reg.loader) t_next.st = ST_POLL;
                if (t_reg.strap_done && !t_reg.loader) t_next.st = ST_APP;
            end
            ST_POLL: begin
                // loop forever on both lines until a start edge shows
                if (!pin_s2_reg[0] || !pin_s2_reg[1]) begin
                    t_next.sel_b = pin_s2_reg[0]; // a wins a tie
                    t_next.st = ST_MEASURE;
                    t_next.tick = '0;
                    t_next.low_sum = 16'h0001; // first low cycle seen here
                    t_next.low_seen = 3'h0;
                    t_next.prev_line = 1'b0;
                end
            end
            ST_MEASURE: begin
                // tick timer counts every cycle since the start edge; low_sum counts the low time
                t_next.tick = t_reg.tick + 16'h0001;
                if (!cur_line) t_next.low_sum = t_reg.low_sum + 16'h0001;
                if (!t_reg.prev_line && cur_line) begin
                    t_next.low_seen = t_reg.low_seen + 3'h1;
                end
                // 0x7f: start and msb are its only lows; done at the rise into parity
                if (t_reg.low_seen == SYNC_LOW_BITS && t_reg.tick >= {t_reg.low_sum[14:0], 1'b0}
                    && cur_line) begin
                    t_next.divisor = {1'b0, t_reg.low_sum[DIV_W-1:1]};
                    t_next.en = t_reg.sel_b ? 2'b10 : 2'b01;
                    t_next.st = ST_ACK;
                end
            end
            ST_ACK: begin
                t_next.tx_byte = ACK_BYTE;
                t_next.tx_go = 1'b1;
                t_next.st = ST_CMD;
            end
            ST_CMD: begin
                // command loop on the chosen port only
                if (t_reg.sel_b ? port_b.rx_valid : port_a.rx_valid) begin
                    t_next.rx_byte = t_reg.sel_b ? port_b.rx_data : port_a.rx_data;
                    t_next.rx_new = 1'b1;
                    t_next.perr = t_reg.perr | rx_fault;
                    if (!cmd_known(t_next.rx_byte)) begin
                        t_next.tx_byte = NACK_BYTE;
                        t_next.tx_go = 1'b1;
                    end
                end
            end
            ST_APP: t_next.en = 2'b00;
            default: t_next.st = ST_IDLE;
        endcase
        // register writes
        if (WR_IN) begin
            unique case (ADDR_IN)
                ADDR_TXDATA: begin
                    if (t_reg.st == ST_CMD) begin
                        t_next.tx_byte = WDATA_IN[7:0];
                        t_next.tx_go = 1'b1;
                    end
                end
                ADDR_CTRL: begin
                    // a fault landing in the same cycle outlives the clear
                    if (WDATA_IN[0]) t_next.perr = rx_fault;
                end
                default: ;
            endcase
        end
        // read answer, next cycle only
        t_next.rdata = '0;
        if (RD_IN) begin
            unique case (ADDR_IN)
                ADDR_STATUS: t_next.rdata = {24'h0, t_reg.perr, t_reg.rx_new,
                    t_reg.sel_b, t_reg.loader, 1'b0, t_reg.st};
                ADDR_DIVISOR: t_next.rdata = {16'h0, t_reg.divisor};
                ADDR_RAM_BASE: t_next.rdata = LOADER_RAM_BASE;
                ADDR_SYSMEM_BASE: t_next.rdata = SYSMEM_BASE;
                ADDR_RXDATA: begin
                    t_next.rdata = {24'h0, t_reg.rx_byte};
                    t_next.rx_new = t_next.rx_new & (t_reg.st != ST_CMD
                        || !(t_reg.sel_b ? port_b.rx_valid : port_a.rx_valid));
                end
                default: t_next.rdata = '0;
            endcase
        end
    end
    // ******************************
    // state register
    // ******************************
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) t_reg <= '0;
        else t_reg <= t_next;
    end
    // ******************************
    // engine wiring
    // ******************************
    assign port_a.enable = t_reg.en[0];
    assign port_b.enable = t_reg.en[1];
    assign port_a.divisor = t_reg.divisor;
    assign port_b.divisor = t_reg.divisor;
    assign port_a.rx_line = pin_s2_reg[0];
    assign port_b.rx_line = pin_s2_reg[1];
    assign port_a.tx_data = t_reg.tx_byte;
    assign port_b.tx_data = t_reg.tx_byte;
    assign port_a.tx_start = t_reg.tx_go & ~t_reg.sel_b;
    assign port_b.tx_start = t_reg.tx_go & t_reg.sel_b;
    // ******************************
    // output flops
    // ******************************
    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            PORT_A_TRANSMIT_OUT <= 1'b1;
            PORT_B_TRANSMIT_OUT <= 1'b1;
            LOADER_MODE_OUT <= 1'b0;
            DEBUG_LINK_BLOCKED_OUT <= 1'b0;
            WDG_REFRESH_OUT <= 1'b0;
            WDG_PRESCALE_OUT <= 4'h0;
            FLASH_WAIT_OUT <= 2'h0;
        end else begin
            PORT_A_TRANSMIT_OUT <= port_a.tx_line;
            PORT_B_TRANSMIT_OUT <= port_b.tx_line;
            LOADER_MODE_OUT <= t_reg.loader;
            DEBUG_LINK_BLOCKED_OUT <= t_reg.loader;
            WDG_REFRESH_OUT <= t_reg.wdg_pulse;
            WDG_PRESCALE_OUT <= t_reg.loader ? WDG_PRESCALE_MAX : 4'h0;
            FLASH_WAIT_OUT <= t_reg.loader ? FLASH_WAIT_STATES : 2'h0;
        end
    end
    assign RDATA_OUT = t_reg.rdata;
endmodule : boot_uart_autodetect

// ---- boot_uart_pkg.sv ----
package boot_uart_pkg;
    // ******************************
    // protocol bytes
    // ******************************
    localparam logic [7:0] SYNC_BYTE = 8'h7f;
    localparam logic [7:0] ACK_BYTE = 8'h79;
    localparam logic [7:0] NACK_BYTE = 8'h1f;
    // ******************************
    // register map (word byte addresses)
    // ******************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DIVISOR = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0c;
    localparam logic [7:0] ADDR_TXDATA = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [7:0] ADDR_RAM_BASE = 8'h18;
    localparam logic [7:0] ADDR_SYSMEM_BASE = 8'h1c;
    // ******************************
    // memory layout and clocking facts
    // ******************************
    localparam logic [31:0] OPTION_BYTE_ADDR = 32'h1ffff800;
    localparam logic [31:0] LOADER_RAM_BASE = 32'h20000000;
    localparam logic [31:0] LOADER_RAM_BYTES = 32'h00000800;
    localparam logic [31:0] SYSMEM_BASE = 32'h1fffec00;
    localparam logic [31:0] SYSMEM_BYTES = 32'h00000c00;
    localparam logic [1:0] FLASH_WAIT_STATES = 2'h1;
    localparam int SYS_CLK_HZ = 24000000;
    localparam int CLK_HZ = 125000000;
    // ******************************
    // frame format and widths
    // ******************************
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = 11;
    localparam int DIV_W = 16;
    localparam logic [3:0] FRAME_LAST = 4'ha;
    localparam logic [3:0] PARITY_POS = 4'h9;
    // sync byte 0x7f holds two low bits, start and bit 7, in separate runs
    localparam logic [2:0] SYNC_LOW_BITS = 3'h2;
    // watchdog refresh interval in us, converted to cycles
    localparam int WDG_REFRESH_US = 100;
    localparam int WDG_REFRESH_CYC = (WDG_REFRESH_US * (CLK_HZ / 1000000));
    localparam logic [3:0] WDG_PRESCALE_MAX = 4'h7;
    // command codes accepted by this loader
    localparam logic [7:0] CMD_GET = 8'h00;
    localparam logic [7:0] CMD_VERSION = 8'h01;
    localparam logic [7:0] CMD_ID = 8'h02;
    // ******************************
    // port selection machine
    // ******************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_POLL = 3'b001,
        ST_MEASURE = 3'b011,
        ST_ACK = 3'b010,
        ST_CMD = 3'b110,
        ST_APP = 3'b111
    } sel_state_t;
endpackage : boot_uart_pkg

// ---- serial_port_if.sv ----
`timescale 1ns/1ps
// carries one candidate port between top and its serial engine
interface serial_port_if;
    logic enable; // port may run
    logic [15:0] divisor; // cycles per bit
    logic rx_line; // synchronised receive level
    logic tx_line; // transmit level
    logic [7:0] rx_data; // received byte
    logic rx_valid; // one-cycle byte pulse
    logic rx_perr; // parity or stop fault on that byte
    logic [7:0] tx_data; // byte to send
    logic tx_start; // one-cycle send request
    logic tx_busy; // sender active
    modport ctrl (output enable, output divisor, output rx_line, output tx_data,
                  output tx_start, input tx_line, input rx_data, input rx_valid,
                  input rx_perr, input tx_busy);
    modport engine (input enable, input divisor, input rx_line, input tx_data,
                    input tx_start, output tx_line, output rx_data, output rx_valid,
                    output rx_perr, output tx_busy);
endinterface : serial_port_if

// ---- serial_engine.sv ----
`timescale 1ns/1ps
// 8e1 receiver and transmitter for one port
module serial_engine
    import boot_uart_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // port link
    serial_port_if.engine sp
);
    typedef struct packed {
        logic rx_run; // receiving a frame
        logic [3:0] rx_idx; // bit index in frame
        logic [15:0] rx_cnt; // cycles inside bit
        logic [9:0] rx_sh; // data, parity, stop
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_perr;
        logic tx_run;
        logic [3:0] tx_idx;
        logic [15:0] tx_cnt;
        logic [10:0] tx_sh;
        logic tx_line;
    } eng_t;
    eng_t s_reg, s_next;
    // ******************************
    // next state
    // ******************************
    always_comb begin
        s_next = s_reg;
        s_next.rx_valid = 1'b0;
        if (!sp.enable) begin
            // disabled port ignores its line entirely
            s_next.rx_run = 1'b0;
            s_next.tx_run = 1'b0;
            s_next.tx_line = 1'b1;
        end else begin
            // receiver: start edge, then sample mid bit
            if (!s_reg.rx_run) begin
                if (!sp.rx_line) begin
                    s_next.rx_run = 1'b1;
                    s_next.rx_idx = 4'h0;
                    s_next.rx_cnt = {1'b0, sp.divisor[15:1]};
                end
            end else if (s_reg.rx_cnt == 16'h0000) begin
                s_next.rx_cnt = sp.divisor - 16'h0001;
                if (s_reg.rx_idx == 4'h0) begin
                    // false start rejected
                    if (sp.rx_line) s_next.rx_run = 1'b0;
                end else begin
                    s_next.rx_sh = {sp.rx_line, s_reg.rx_sh[9:1]};
                end
                if (s_reg.rx_idx == FRAME_LAST) begin
                    s_next.rx_run = 1'b0;
                    s_next.rx_data = s_reg.rx_sh[8:1];
                    s_next.rx_valid = 1'b1;
                    // even parity over data and parity bit, stop must be high
                    s_next.rx_perr = (^s_reg.rx_sh[9:1]) | ~sp.rx_line;
                end
                s_next.rx_idx = s_reg.rx_idx + 4'h1;
            end else begin
                s_next.rx_cnt = s_reg.rx_cnt - 16'h0001;
            end
            // transmitter: start, 8 data lsb first, even parity, stop
            if (!s_reg.tx_run) begin
                if (sp.tx_start) begin
                    s_next.tx_run = 1'b1;
                    s_next.tx_idx = 4'h0;
                    s_next.tx_cnt = sp.divisor - 16'h0001;
                    s_next.tx_sh = {1'b1, ^sp.tx_data, sp.tx_data, 1'b0};
                    s_next.tx_line = 1'b0;
                end
            end else if (s_reg.tx_cnt == 16'h0000) begin
                s_next.tx_cnt = sp.divisor - 16'h0001;
                if (s_reg.tx_idx == FRAME_LAST) begin
                    s_next.tx_run = 1'b0;
                    s_next.tx_line = 1'b1;
                end else begin
                    s_next.tx_idx = s_reg.tx_idx + 4'h1;
                    s_next.tx_line = s_reg.tx_sh[s_reg.tx_idx + 4'h1];
                end
            end else begin
                s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
            end
        end
    end
    // ******************************
    // state register
    // ******************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
            s_reg.tx_line <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
    assign sp.tx_line = s_reg.tx_line;
    assign sp.rx_data = s_reg.rx_data;
    assign sp.rx_valid = s_reg.rx_valid;
    assign sp.rx_perr = s_reg.rx_perr;
    assign sp.tx_busy = s_reg.tx_run | sp.tx_start;
endmodule : serial_engine

// ---- boot_uart_host_model.sv ----
`timescale 1ns/1ps
// ******************************
// host end of one serial port
// ******************************
module boot_uart_host_model #(
    parameter int BIT = 32 // cycles per bit
) (
    // clock
    input wire logic clk_in,
    // serial lines
    output logic rx_out,
    input wire logic tx_in
);
    // idle mark level, never floating while unused
    initial rx_out = 1'b1;
    // one 8e1 frame, lsb first; bad_par only where a scenario asks
    task automatic send_byte(input logic [7:0] d, input logic bad_par);
        logic [10:0] fr;
        fr = {1'b1, ^d ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_in);
            rx_out <= fr[i];
            repeat (BIT - 1) @(posedge clk_in);
        end
    endtask : send_byte
    // sample a reply at bit centres; got low on timeout or bad frame
    task automatic recv_byte(output logic [7:0] d, output logic got);
        int n;
        logic p;
        n = 0;
        got = 1'b0;
        d = 8'h00;
        while (tx_in === 1'b1 && n < 30 * BIT) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 30 * BIT) return;
        repeat (BIT / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_in);
            d[i] = tx_in;
        end
        repeat (BIT) @(posedge clk_in);
        p = tx_in;
        repeat (BIT) @(posedge clk_in);
        got = (p === ^d) && (tx_in === 1'b1);
    endtask : recv_byte
    // wait for a long quiet gap so trailing reply bytes are skipped
    task automatic drain();
        int n;
        int q;
        n = 0;
        q = 0;
        while (q < 15 * BIT && n < 8000) begin
            @(posedge clk_in);
            n++;
            q = (tx_in === 1'b1) ? q + 1 : 0;
        end
    endtask : drain
endmodule : boot_uart_host_model

// ---- boot_uart_autodetect_chk.sv ----
`timescale 1ns/1ps
// ******************************
// port-level checker
// ******************************
module boot_uart_autodetect_chk
    import boot_uart_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // register port
    input wire logic RD_IN,
    input wire logic [31:0] RDATA_OUT,
    // serial and status
    input wire logic PORT_A_TRANSMIT_OUT,
    input wire logic PORT_B_TRANSMIT_OUT,
    input wire logic LOADER_MODE_OUT,
    input wire logic DEBUG_LINK_BLOCKED_OUT,
    input wire logic WDG_REFRESH_OUT,
    input wire logic [3:0] WDG_PRESCALE_OUT,
    input wire logic [1:0] FLASH_WAIT_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    // cycles since last refresh; a stalled refresh overruns it
    int gap_reg;
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN || WDG_REFRESH_OUT || !LOADER_MODE_OUT) begin
            gap_reg <= 0;
        end else begin
            gap_reg <= gap_reg + 1;
        end
    end
    a_prescale_max: assert property (WDG_PRESCALE_OUT == (LOADER_MODE_OUT ? 4'h7 : 4'h0))
        else $error("watchdog prescale wrong");
    a_wait_state: assert property (FLASH_WAIT_OUT == (LOADER_MODE_OUT ? 2'h1 : 2'h0))
        else $error("flash wait state wrong");
    a_debug_blocked: assert property (DEBUG_LINK_BLOCKED_OUT == LOADER_MODE_OUT)
        else $error("debug block differs from loader mode");
    a_loader_held: assert property ($past(LOADER_MODE_OUT) |-> LOADER_MODE_OUT)
        else $error("loader mode dropped without reset");
    a_wdg_single: assert property (WDG_REFRESH_OUT |=> !WDG_REFRESH_OUT)
        else $error("refresh pulse too long");
    a_wdg_gap: assert property (!WDG_REFRESH_OUT |-> gap_reg < WDG_REFRESH_CYC)
        else $error("refresh overdue");
    a_wdg_idle: assert property (!LOADER_MODE_OUT |-> !WDG_REFRESH_OUT)
        else $error("refresh outside loader mode");
    a_tx_quiet: assert property (!LOADER_MODE_OUT |-> PORT_A_TRANSMIT_OUT && PORT_B_TRANSMIT_OUT)
        else $error("transmit active outside loader");
    a_one_port: assert property (!PORT_A_TRANSMIT_OUT |-> PORT_B_TRANSMIT_OUT)
        else $error("both ports transmitting");
    a_rdata_clear: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0)
        else $error("read data outside read slot");
    c_loader: cover property ($rose(LOADER_MODE_OUT));
    c_refresh: cover property (WDG_REFRESH_OUT);
    c_tx_b: cover property ($fell(PORT_B_TRANSMIT_OUT));
endmodule : boot_uart_autodetect_chk
bind boot_uart_autodetect boot_uart_autodetect_chk i_boot_uart_autodetect_chk (
    .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .PORT_A_TRANSMIT_OUT(PORT_A_TRANSMIT_OUT), .PORT_B_TRANSMIT_OUT(PORT_B_TRANSMIT_OUT),
    .LOADER_MODE_OUT(LOADER_MODE_OUT), .DEBUG_LINK_BLOCKED_OUT(DEBUG_LINK_BLOCKED_OUT),
    .WDG_REFRESH_OUT(WDG_REFRESH_OUT), .WDG_PRESCALE_OUT(WDG_PRESCALE_OUT),
    .FLASH_WAIT_OUT(FLASH_WAIT_OUT));

// ---- boot_uart_autodetect_tb.sv ----
`timescale 1ns/1ps
module boot_uart_autodetect_tb;
    import boot_uart_pkg::*;
    localparam int BIT = 32; // host bit time, short to keep the run brief
    // ******************************
    // signals
    // ******************************
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic pin = 1'b1;
    logic opt = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic rx_a, rx_b, tx_a, tx_b, loader, dbg, wdg;
    logic [3:0] presc;
    logic [1:0] fws;
    int error_cnt = 0;
    int check_count = 0;
    always #4 clk = ~clk; // 125 MHz
    boot_uart_autodetect i_boot_uart_autodetect (.CLK_IN(clk), .ARST_N_IN(arst_n),
        .BOOT_SELECT_PIN_IN(pin), .BOOT_SELECT_OPTION_BIT_IN(opt), .PORT_A_RECEIVE_IN(rx_a),
        .PORT_A_TRANSMIT_OUT(tx_a), .PORT_B_RECEIVE_IN(rx_b), .PORT_B_TRANSMIT_OUT(tx_b),
        .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .LOADER_MODE_OUT(loader), .DEBUG_LINK_BLOCKED_OUT(dbg), .WDG_REFRESH_OUT(wdg),
        .WDG_PRESCALE_OUT(presc), .FLASH_WAIT_OUT(fws));
    boot_uart_host_model #(.BIT(BIT)) i_host_a (.clk_in(clk), .rx_out(rx_a), .tx_in(tx_a));
    boot_uart_host_model #(.BIT(BIT)) i_host_b (.clk_in(clk), .rx_out(rx_b), .tx_in(tx_b));
    // ******************************
    // shared tasks
    // ******************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    // read data stand in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd
    task automatic do_reset(input logic p, input logic o);
        arst_n <= 1'b0;
        pin <= p;
        opt <= o;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask : do_reset
    task automatic expect_b(input logic [7:0] exp);
        logic [7:0] d;
        logic got;
        i_host_b.recv_byte(d, got);
        check(32'(got), 32'h1);
        check(32'(d), 32'(exp));
    endtask : expect_b
    task automatic status_is(input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] s;
        bus_rd(ADDR_STATUS, s);
        check(s & mask, exp);
    endtask : status_is
    // ******************************
    // scenarios
    // ******************************
    task automatic t_boot_on();
        logic [31:0] s;
        check(32'({loader, dbg, presc, fws}), 32'({2'b11, 4'h7, 2'h1}));
        repeat (300) @(posedge clk);
        status_is(32'h3f, 32'h11);
        bus_rd(8'h40, s);
        check(s, 32'h0);
        bus_rd(ADDR_RAM_BASE, s);
        check(s, LOADER_RAM_BASE);
        bus_rd(ADDR_SYSMEM_BASE, s);
        check(s, SYSMEM_BASE);
    endtask : t_boot_on
    task automatic t_sync_b();
        logic [31:0] d;
        // the reply starts while the host is still sending parity and stop
        fork
            i_host_b.send_byte(SYNC_BYTE, 1'b0);
            expect_b(ACK_BYTE);
        join
        status_is(32'h3f, 32'h36);
        bus_rd(ADDR_DIVISOR, d);
        check(32'(d >= BIT - 1 && d <= BIT + 1), 32'h1);
    endtask : t_sync_b
    task automatic t_ignore_a();
        logic [7:0] d;
        logic got;
        i_host_a.send_byte(SYNC_BYTE, 1'b0);
        i_host_a.recv_byte(d, got);
        check(32'(got), 32'h0);
        status_is(32'h3f, 32'h36);
    endtask : t_ignore_a
    task automatic t_cmds();
        logic [7:0] cmds [3] = '{CMD_GET, CMD_VERSION, CMD_ID};
        logic [7:0] d;
        logic got;
        logic [31:0] s;
        fork
            i_host_b.send_byte(8'h55, 1'b0);
            expect_b(NACK_BYTE);
        join
        i_host_b.drain();
        // known commands get no reply; the byte waits in the data register
        for (int i = 0; i < 3; i++) begin
            fork
                i_host_b.send_byte(cmds[i], 1'b0);
                i_host_b.recv_byte(d, got);
            join
            check(32'(got), 32'h0);
            bus_rd(ADDR_RXDATA, s);
            check(s, 32'(cmds[i]));
        end
        bus_wr(ADDR_TXDATA, 32'ha5);
        expect_b(8'ha5);
    endtask : t_cmds
    task automatic t_perr();
        i_host_b.send_byte(8'h33, 1'b1);
        i_host_b.drain();
        status_is(32'h80, 32'h80);
        bus_wr(ADDR_CTRL, 32'h1);
        status_is(32'h80, 32'h0);
    endtask : t_perr
    task automatic t_wdg();
        int n;
        n = 0;
        while (wdg !== 1'b1 && n < 13000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(32'(n < 13000), 32'h1);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (wdg !== 1'b1 && n < 13000);
        check(32'(n), 32'(WDG_REFRESH_CYC));
    endtask : t_wdg
    // either strap missing keeps the loader out
    task automatic t_boot_off();
        for (int i = 0; i < 2; i++) begin
            do_reset(i[0], ~i[0]);
            check(32'({loader, dbg, presc, fws, tx_a, tx_b}), 32'h3);
        end
    endtask : t_boot_off
    // ******************************
    // main sequence and hang guard
    // ******************************
    initial begin
        do_reset(1'b1, 1'b1);
        t_boot_on();
        t_sync_b();
        t_ignore_a();
        t_cmds();
        t_perr();
        t_wdg();
        t_boot_off();
        wrap_up();
    end
    initial begin
        #800000;
        error_cnt++;
        wrap_up();
    end
endmodule : boot_uart_autodetect_tb
